// ===== common/alu_pkg.sv
package alu_pkg;
  // operand and word widths
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int OP_W = 5;
  // status flag bit positions
  localparam int FLAGS_W = 5;
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;
  // register byte offsets on the bus
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_OPND_ADDR = 12'h004;
  localparam logic [11:0] OFS_WORK = 12'h008;
  localparam logic [11:0] OFS_FLAGS = 12'h00C;
  localparam logic [11:0] OFS_TPTR_LOW = 12'h010;
  localparam logic [11:0] OFS_TPTR_HIGH = 12'h014;
  localparam logic [11:0] OFS_TLATCH = 12'h018;
  localparam logic [11:0] OFS_STATUS = 12'h01C;
  localparam logic [11:0] OFS_DMEM_PTR = 12'h020;
  localparam logic [11:0] OFS_DMEM_DATA = 12'h024;
  // command word field positions
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  // values after reset
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 5'h00;
  // decimal adjust constants
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  // operation codes
  localparam logic [OP_W-1:0] OP_XOR_W = 5'h00;
  localparam logic [OP_W-1:0] OP_XOR_M = 5'h01;
  localparam logic [OP_W-1:0] OP_XOR_IMM = 5'h02;
  localparam logic [OP_W-1:0] OP_ADC_W = 5'h03;
  localparam logic [OP_W-1:0] OP_ADC_M = 5'h04;
  localparam logic [OP_W-1:0] OP_ADD_W = 5'h05;
  localparam logic [OP_W-1:0] OP_ADD_M = 5'h06;
  localparam logic [OP_W-1:0] OP_AND_W = 5'h07;
  localparam logic [OP_W-1:0] OP_AND_M = 5'h08;
  localparam logic [OP_W-1:0] OP_OR_W = 5'h09;
  localparam logic [OP_W-1:0] OP_OR_M = 5'h0A;
  localparam logic [OP_W-1:0] OP_ZERO_FILL = 5'h0B;
  localparam logic [OP_W-1:0] OP_ZERO_BIT = 5'h0C;
  localparam logic [OP_W-1:0] OP_INV_M = 5'h0D;
  localparam logic [OP_W-1:0] OP_INV_W = 5'h0E;
  localparam logic [OP_W-1:0] OP_DEC_ADJ = 5'h0F;
  localparam logic [OP_W-1:0] OP_DECR_M = 5'h10;
  localparam logic [OP_W-1:0] OP_DECR_W = 5'h11;
  localparam logic [OP_W-1:0] OP_INCR_M = 5'h12;
  localparam logic [OP_W-1:0] OP_INCR_W = 5'h13;
  localparam logic [OP_W-1:0] OP_MOVE_TO_W = 5'h14;
  localparam logic [OP_W-1:0] OP_MOVE_TO_M = 5'h15;
  localparam logic [OP_W-1:0] OP_ROT_M = 5'h16;
  localparam logic [OP_W-1:0] OP_ROT_W = 5'h17;
  localparam logic [OP_W-1:0] OP_ROTC_M = 5'h18;
  localparam logic [OP_W-1:0] OP_ROTC_W = 5'h19;
  localparam logic [OP_W-1:0] OP_TBL_PAGED = 5'h1A;
  localparam logic [OP_W-1:0] OP_TBL_LAST = 5'h1B;
  localparam logic [OP_W-1:0] OP_TBL_PRE = 5'h1C;
  localparam logic [OP_W-1:0] OP_TBL_LAST_PRE = 5'h1D;
endpackage

// ===== rtl/alu_core.sv
`timescale 1ns/1ps
module alu_core
  import alu_pkg::*;
(
  input wire logic [OP_W-1:0] op,
  input wire logic [7:0] work,
  input wire logic [7:0] operand,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic [FLAGS_W-1:0] flags_in,
  output logic [7:0] result,
  output logic to_work,
  output logic to_mem,
  output logic [FLAGS_W-1:0] flags_out
);
  logic cin;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic upd_z;
  logic upd_add;
  logic lo_fix;
  logic hi_fix;
  logic [7:0] adj_val;

  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic c);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, c};
  endfunction

  // shared adder; carry in only for the with-carry forms
  assign cin = (op == OP_ADC_W || op == OP_ADC_M) ? flags_in[FLAG_C] : 1'b0; // [RULE7] [RULE8]
  assign sum9 = add9(work, operand, cin);
  assign half5 = {1'b0, work[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
  // decimal fix judged on the original nibbles
  assign lo_fix = (work[3:0] > BCD_MAX) || flags_in[FLAG_AC]; // [RULE14]
  assign hi_fix = (work[7:4] > BCD_MAX) || flags_in[FLAG_C]; // [RULE14]
  assign adj_val = {hi_fix ? BCD_FIX : 4'h0, lo_fix ? BCD_FIX : 4'h0};

  // result and destination select
  always_comb begin
    result = operand;
    to_work = 1'b0;
    to_mem = 1'b0;
    upd_z = 1'b0;
    upd_add = 1'b0;
    case (op)
      OP_XOR_W: begin result = work ^ operand; to_work = 1'b1; upd_z = 1'b1; end // [RULE5]
      OP_XOR_M: begin result = work ^ operand; to_mem = 1'b1; upd_z = 1'b1; end // [RULE5]
      OP_XOR_IMM: begin result = work ^ imm; to_work = 1'b1; upd_z = 1'b1; end // [RULE5]
      OP_ADC_W, OP_ADD_W: begin
        result = sum9[7:0];
        to_work = 1'b1;
        upd_add = 1'b1;
      end
      OP_ADC_M, OP_ADD_M: begin
        result = sum9[7:0];
        to_mem = 1'b1;
        upd_add = 1'b1;
      end
      OP_AND_W: begin result = work & operand; to_work = 1'b1; upd_z = 1'b1; end // [RULE9]
      OP_AND_M: begin result = work & operand; to_mem = 1'b1; upd_z = 1'b1; end // [RULE9]
      OP_OR_W: begin result = work | operand; to_work = 1'b1; upd_z = 1'b1; end // [RULE10]
      OP_OR_M: begin result = work | operand; to_mem = 1'b1; upd_z = 1'b1; end // [RULE10]
      OP_ZERO_FILL: begin result = BYTE_RST; to_mem = 1'b1; end // [RULE11]
      OP_ZERO_BIT: begin result[bit_sel] = 1'b0; to_mem = 1'b1; end // [RULE12]
      OP_INV_M: begin result = ~operand; to_mem = 1'b1; upd_z = 1'b1; end // [RULE13]
      OP_INV_W: begin result = ~operand; to_work = 1'b1; upd_z = 1'b1; end // [RULE13]
      OP_DEC_ADJ: begin result = work + adj_val; to_mem = 1'b1; end // [RULE14]
      OP_DECR_M: begin result = operand - 8'h01; to_mem = 1'b1; upd_z = 1'b1; end // [RULE16]
      OP_DECR_W: begin result = operand - 8'h01; to_work = 1'b1; upd_z = 1'b1; end // [RULE16]
      OP_INCR_M: begin result = operand + 8'h01; to_mem = 1'b1; upd_z = 1'b1; end // [RULE17]
      OP_INCR_W: begin result = operand + 8'h01; to_work = 1'b1; upd_z = 1'b1; end // [RULE17]
      OP_MOVE_TO_W: to_work = 1'b1; // [RULE18]
      OP_MOVE_TO_M: begin result = work; to_mem = 1'b1; end // [RULE19]
      OP_ROT_M: begin result = {operand[6:0], operand[7]}; to_mem = 1'b1; end // [RULE20]
      OP_ROT_W: begin result = {operand[6:0], operand[7]}; to_work = 1'b1; end // [RULE20]
      OP_ROTC_M: begin result = {operand[6:0], flags_in[FLAG_C]}; to_mem = 1'b1; end // [RULE21]
      OP_ROTC_W: begin result = {operand[6:0], flags_in[FLAG_C]}; to_work = 1'b1; end // [RULE21]
      default: result = operand;
    endcase
  end

  // untouched flags keep their value
  always_comb begin
    flags_out = flags_in; // [RULE22]
    if (upd_add) begin
      flags_out[FLAG_C] = sum9[8]; // [RULE7] [RULE8]
      flags_out[FLAG_AC] = half5[4];
      flags_out[FLAG_OV] = (work[7] == operand[7]) && (sum9[7] != work[7]);
      flags_out[FLAG_SC] = ((work[7] == operand[7]) && (sum9[7] != work[7])) ^ sum9[7];
    end
    if (upd_z || upd_add) begin
      flags_out[FLAG_Z] = ~|result;
    end
    if (op == OP_DEC_ADJ) begin
      flags_out[FLAG_C] = hi_fix; // [RULE15]
    end
    if (op == OP_ROTC_M || op == OP_ROTC_W) begin
      flags_out[FLAG_C] = operand[7]; // [RULE21]
    end
  end
endmodule

// ===== rtl/data_store.sv
`timescale 1ns/1ps
module data_store #(
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [7:0] rdata_b
);
  logic [7:0] mem_reg [2**AW];

  // flat store, one write port, two read ports
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 2**AW; i++) mem_reg[i] <= 8'h00;
    end else if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  assign rdata_a = mem_reg[raddr_a];
  assign rdata_b = mem_reg[raddr_b];
endmodule

// ===== rtl/table_alu_top.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] paged table read: word to memory and latch
// [RULE2] last-page read uses low pointer as offset
// [RULE3] preincrement low pointer, then paged read
// [RULE4] preincrement low pointer, then last-page read
// [RULE5] xor with memory or immediate, zero only
// [RULE6] extended ops reach any memory address
// [RULE7] add with carry, five flags updated
// [RULE8] add without carry, five flags updated
// [RULE9] and, zero flag only
// [RULE10] or, zero flag only
// [RULE11] byte clear, no flag change
// [RULE12] bit clear, others and flags untouched
// [RULE13] invert to memory or work, zero flag
// [RULE14] decimal adjust nibbles into memory
// [RULE15] decimal adjust changes carry only
// [RULE16] decrement to memory or work, zero flag
// [RULE17] increment to memory or work, zero flag
// [RULE18] load work from memory, flags kept
// [RULE19] store work to memory, flags kept
// [RULE20] rotate left, top bit to bit zero
// [RULE21] rotate left through carry
// [RULE22] unlisted flags keep their value
module table_alu_top
  import alu_pkg::*;
#(
  parameter int PROG_AW = 14,
  parameter int DMEM_AW = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PROG_AW-1:0] prog_addr,
  output logic prog_req,
  input wire logic [WORD_W-1:0] prog_data,
  output logic busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TBL_ADDR, ST_TBL_DATA} state_t;

  state_t state_reg;
  state_t state_next;
  logic [OP_W-1:0] op_reg;
  logic [2:0] bit_reg;
  logic [7:0] imm_reg;
  logic [DMEM_AW-1:0] opnd_addr_reg;
  logic [7:0] work_reg;
  logic [FLAGS_W-1:0] flags_reg;
  logic [7:0] table_pointer_low_reg;
  logic [7:0] table_pointer_high_reg;
  logic [7:0] table_high_byte_latch_reg;
  logic [DMEM_AW-1:0] dmem_ptr_reg;
  logic [PROG_AW-1:0] prog_addr_reg;
  logic busy_d_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // bus decode
  logic acc_phase;
  logic wr_take;
  logic hit_cmd;
  logic hit_addr;
  logic hit_work;
  logic hit_flags;
  logic hit_tpl;
  logic hit_tph;
  logic hit_tlatch;
  logic hit_status;
  logic hit_dptr;
  logic hit_ddata;
  logic hit_any;
  logic start_op;
  logic is_table_op;
  logic is_pre_op;
  logic is_last_op;

  // datapath wires
  logic [7:0] operand;
  logic [7:0] dmem_rd_bus;
  logic [7:0] alu_result;
  logic alu_to_work;
  logic alu_to_mem;
  logic [FLAGS_W-1:0] alu_flags;
  logic [7:0] tpl_eff;
  logic [15:0] paged_full;
  logic [PROG_AW-1:0] tbl_addr;
  logic mem_we;
  logic [DMEM_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [31:0] rd_mux;
  logic exec_cycle;
  logic tbl_data_cycle;
  logic bus_mem_wr;

  // answer only once an operation and its settling cycle are over
  assign busy = (state_reg != ST_IDLE);
  assign pready = ~busy & ~busy_d_reg;
  assign acc_phase = psel & penable & pready;
  assign wr_take = acc_phase & pwrite;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & acc_phase;

  // address decode
  assign hit_cmd = (paddr == OFS_CMD);
  assign hit_addr = (paddr == OFS_OPND_ADDR);
  assign hit_work = (paddr == OFS_WORK);
  assign hit_flags = (paddr == OFS_FLAGS);
  assign hit_tpl = (paddr == OFS_TPTR_LOW);
  assign hit_tph = (paddr == OFS_TPTR_HIGH);
  assign hit_tlatch = (paddr == OFS_TLATCH);
  assign hit_status = (paddr == OFS_STATUS);
  assign hit_dptr = (paddr == OFS_DMEM_PTR);
  assign hit_ddata = (paddr == OFS_DMEM_DATA);
  assign hit_any = hit_cmd | hit_addr | hit_work | hit_flags | hit_tpl | hit_tph
                 | hit_tlatch | hit_status | hit_dptr | hit_ddata;

  // one table-range decode shared by the sequencer and the decode check
  function automatic logic tbl_code(input logic [OP_W-1:0] code);
    tbl_code = (code >= OP_TBL_PAGED) && (code <= OP_TBL_LAST_PRE);
  endfunction

  // command kind
  assign start_op = wr_take & hit_cmd;
  assign is_table_op = tbl_code(op_reg);
  assign is_pre_op = (op_reg == OP_TBL_PRE) || (op_reg == OP_TBL_LAST_PRE);
  assign is_last_op = (op_reg == OP_TBL_LAST) || (op_reg == OP_TBL_LAST_PRE);

  // table address forming; increment wraps within the low pointer
  assign tpl_eff = is_pre_op ? table_pointer_low_reg + 8'h01 : table_pointer_low_reg; // [RULE3] [RULE4]
  assign paged_full = {table_pointer_high_reg, tpl_eff};
  assign tbl_addr = is_last_op ? {{(PROG_AW-8){1'b1}}, tpl_eff} // [RULE2] [RULE4]
                               : paged_full[PROG_AW-1:0]; // [RULE1] [RULE3]
  assign prog_addr = prog_addr_reg;
  assign prog_req = (state_reg == ST_TBL_DATA);

  // the full-width operand address ignores any bank selection
  assign exec_cycle = (state_reg == ST_EXEC);
  assign tbl_data_cycle = (state_reg == ST_TBL_DATA);
  assign bus_mem_wr = wr_take & hit_ddata;
  assign mem_we = (exec_cycle & alu_to_mem) | tbl_data_cycle | bus_mem_wr;
  assign mem_waddr = bus_mem_wr ? dmem_ptr_reg : opnd_addr_reg; // [RULE6]
  assign mem_wdata = bus_mem_wr ? pwdata[7:0]
                   : tbl_data_cycle ? prog_data[7:0] // [RULE1]
                   : alu_result;

  data_store #(
    .AW(DMEM_AW)
  ) u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(opnd_addr_reg),
    .rdata_a(operand),
    .raddr_b(dmem_ptr_reg),
    .rdata_b(dmem_rd_bus)
  );

  alu_core u_alu (
    .op(op_reg),
    .work(work_reg),
    .operand(operand),
    .imm(imm_reg),
    .bit_sel(bit_reg),
    .flags_in(flags_reg),
    .result(alu_result),
    .to_work(alu_to_work),
    .to_mem(alu_to_mem),
    .flags_out(alu_flags)
  );

  // read mux; unmapped reads give zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cmd) begin
      rd_mux = {8'h00, imm_reg, 5'h00, bit_reg, 3'h0, op_reg};
    end else if (hit_addr) begin
      rd_mux[DMEM_AW-1:0] = opnd_addr_reg;
    end else if (hit_work) begin
      rd_mux[7:0] = work_reg;
    end else if (hit_flags) begin
      rd_mux[FLAGS_W-1:0] = flags_reg;
    end else if (hit_tpl) begin
      rd_mux[7:0] = table_pointer_low_reg;
    end else if (hit_tph) begin
      rd_mux[7:0] = table_pointer_high_reg;
    end else if (hit_tlatch) begin
      rd_mux[7:0] = table_high_byte_latch_reg;
    end else if (hit_status) begin
      rd_mux[0] = busy;
    end else if (hit_dptr) begin
      rd_mux[DMEM_AW-1:0] = dmem_ptr_reg;
    end else if (hit_ddata) begin
      rd_mux[7:0] = dmem_rd_bus;
    end
  end

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_op) begin
          // spare codes above the table range run as a harmless no-op
          state_next = tbl_code(pwdata[OP_W-1:0]) ? ST_TBL_ADDR : ST_EXEC;
        end
      end
      ST_EXEC: state_next = ST_IDLE;
      ST_TBL_ADDR: state_next = ST_TBL_DATA;
      ST_TBL_DATA: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      busy_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_d_reg <= busy;
    end
  end

  // read data captured every selected cycle, so it is fresh at pready
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= (psel & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_reg <= psel & ~hit_any;
    end
  end

  // command and operand address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg <= OP_XOR_W;
      bit_reg <= 3'h0;
      imm_reg <= BYTE_RST;
      opnd_addr_reg <= '0;
      dmem_ptr_reg <= '0;
    end else begin
      if (start_op) begin
        op_reg <= pwdata[OP_W-1:0];
        bit_reg <= pwdata[CMD_BIT_LSB +: 3];
        imm_reg <= pwdata[CMD_IMM_LSB +: 8];
      end
      if (wr_take & hit_addr) opnd_addr_reg <= pwdata[DMEM_AW-1:0]; // [RULE6]
      if (wr_take & hit_dptr) dmem_ptr_reg <= pwdata[DMEM_AW-1:0];
    end
  end

  // working register and flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      work_reg <= BYTE_RST;
      flags_reg <= FLAGS_RST;
    end else begin
      if (exec_cycle) begin
        if (alu_to_work) work_reg <= alu_result; // [RULE18]
        flags_reg <= alu_flags; // [RULE22]
      end else begin
        if (wr_take & hit_work) work_reg <= pwdata[7:0];
        if (wr_take & hit_flags) flags_reg <= pwdata[FLAGS_W-1:0];
      end
    end
  end

  // table pointers, latch and program address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      table_pointer_low_reg <= BYTE_RST;
      table_pointer_high_reg <= BYTE_RST;
      table_high_byte_latch_reg <= BYTE_RST;
      prog_addr_reg <= '0;
    end else begin
      if (state_reg == ST_TBL_ADDR) begin
        table_pointer_low_reg <= tpl_eff; // [RULE3] [RULE4]
        prog_addr_reg <= tbl_addr; // [RULE1] [RULE2]
      end else if (wr_take & hit_tpl) begin
        table_pointer_low_reg <= pwdata[7:0];
      end
      if (wr_take & hit_tph) table_pointer_high_reg <= pwdata[7:0];
      if (tbl_data_cycle) table_high_byte_latch_reg <= prog_data[15:8]; // [RULE1] [RULE2]
    end
  end

  // checks
  sequence tbl_walk;
    (state_reg == ST_TBL_ADDR) ##1 (state_reg == ST_TBL_DATA);
  endsequence

  a_tbl_latch_load: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
    tbl_data_cycle |=> table_high_byte_latch_reg == $past(prog_data[15:8]))
    else $error("latch missed the high byte");

  a_tbl_low_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
    tbl_data_cycle |-> mem_we && mem_wdata == prog_data[7:0] && mem_waddr == opnd_addr_reg)
    else $error("low byte not written to memory");

  a_last_page_addr: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    (state_reg == ST_TBL_ADDR && is_last_op) |=>
      prog_addr_reg[PROG_AW-1:8] == {(PROG_AW-8){1'b1}}
      && prog_addr_reg[7:0] == table_pointer_low_reg)
    else $error("last page address wrong");

  a_preinc_ptr: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
    (state_reg == ST_TBL_ADDR && is_pre_op) |=>
      table_pointer_low_reg == $past(table_pointer_low_reg) + 8'h01)
    else $error("low pointer not incremented");

  a_tbl_flags_kept: assert property (@(posedge clk) disable iff (sys_rst) // [RULE22]
    tbl_walk |=> flags_reg == $past(flags_reg, 2) && work_reg == $past(work_reg, 2))
    else $error("table read changed flags or work");

  a_xor_to_work: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
    (exec_cycle && op_reg == OP_XOR_W) |=>
      work_reg == ($past(work_reg) ^ $past(operand)) && flags_reg[FLAG_Z] == (work_reg == 8'h00))
    else $error("xor result or zero flag wrong");

  a_clear_byte: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
    (exec_cycle && op_reg == OP_ZERO_FILL) |-> mem_we && mem_wdata == 8'h00 ##1 $stable(flags_reg))
    else $error("clear wrote wrong value or moved flags");

  a_rot_carry: assert property (@(posedge clk) disable iff (sys_rst) // [RULE21]
    (exec_cycle && op_reg == OP_ROTC_M) |->
      mem_wdata == {operand[6:0], flags_reg[FLAG_C]} ##1 flags_reg[FLAG_C] == $past(operand[7]))
    else $error("rotate through carry wrong");

  a_op_finishes: assert property (@(posedge clk) disable iff (sys_rst) // busy drops within three cycles of the command
    start_op |=> busy ##[1:2] !busy)
    else $error("operation did not finish in time");

  a_tbl_decode_match: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
    (state_reg == ST_TBL_ADDR) |-> is_table_op)
    else $error("table walk started for a non-table code");
endmodule

// ===== testbench/test_table_alu_top.sv
`timescale 1ns/1ps
module test_table_alu_top
  import alu_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [13:0] prog_addr;
  logic prog_req;
  logic [WORD_W-1:0] prog_data;
  logic busy;
  int n_tests = 0;
  int n_mismatch = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  table_alu_top #(.PROG_AW(14), .DMEM_AW(10)) table_alu_top_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_addr(prog_addr), .prog_req(prog_req), .prog_data(prog_data), .busy(busy)
  );

  // program word pattern; every address bit shows in the word
  function automatic logic [15:0] pword(input logic [13:0] a);
    return {a[13:6] ^ 8'h81, a[7:0] ^ 8'h5A};
  endfunction

  // program store: inverted word outside the fetch cycle, so stale reads show up
  always_comb begin
    prog_data = prog_req ? pword(prog_addr) : ~pword(prog_addr);
  end

  task automatic report_and_stop();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
  endtask

  // reference behaviour of the alu ops, kept independent of the design
  task automatic model(input logic [4:0] op, input logic [7:0] w, input logic [7:0] m,
                       input logic [7:0] imm, input logic [2:0] b, input logic [4:0] f,
                       output logic [7:0] ew, output logic [7:0] em, output logic [4:0] ef);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic cin, lo, hi;
    ew = w;
    em = m;
    ef = f;
    cin = (op == OP_ADC_W || op == OP_ADC_M) & f[FLAG_C];
    s = w + m + cin;
    h = w[3:0] + m[3:0] + cin;
    lo = (w[3:0] > BCD_MAX) || f[FLAG_AC];
    hi = (w[7:4] > BCD_MAX) || f[FLAG_C];
    case (op)
      OP_XOR_W, OP_XOR_M: r = w ^ m;
      OP_XOR_IMM: r = w ^ imm;
      OP_ADC_W, OP_ADC_M, OP_ADD_W, OP_ADD_M: begin
        r = s[7:0];
        ef[FLAG_C] = s[8];
        ef[FLAG_AC] = h[4];
        ef[FLAG_OV] = (w[7] == m[7]) && (r[7] != w[7]);
        ef[FLAG_SC] = ef[FLAG_OV] ^ r[7];
      end
      OP_AND_W, OP_AND_M: r = w & m;
      OP_OR_W, OP_OR_M: r = w | m;
      OP_ZERO_BIT: r = m & ~(8'h01 << b);
      OP_INV_M, OP_INV_W: r = ~m;
      OP_DEC_ADJ: begin
        r = w + {(hi ? BCD_FIX : 4'h0), (lo ? BCD_FIX : 4'h0)};
        ef[FLAG_C] = hi;
      end
      OP_DECR_M, OP_DECR_W: r = m - 8'h01;
      OP_INCR_M, OP_INCR_W: r = m + 8'h01;
      OP_MOVE_TO_W: r = m;
      OP_MOVE_TO_M: r = w;
      OP_ROT_M, OP_ROT_W: r = {m[6:0], m[7]};
      OP_ROTC_M, OP_ROTC_W: begin
        r = {m[6:0], f[FLAG_C]};
        ef[FLAG_C] = m[7];
      end
      default: r = 8'h00;
    endcase
    if (!(op inside {OP_ZERO_FILL, OP_ZERO_BIT, OP_DEC_ADJ, OP_MOVE_TO_W, OP_MOVE_TO_M,
                     OP_ROT_M, OP_ROT_W, OP_ROTC_M, OP_ROTC_W})) ef[FLAG_Z] = (r == 8'h00);
    if (op inside {OP_XOR_W, OP_XOR_IMM, OP_ADC_W, OP_ADD_W, OP_AND_W, OP_OR_W, OP_INV_W,
                   OP_DECR_W, OP_INCR_W, OP_MOVE_TO_W, OP_ROT_W, OP_ROTC_W}) ew = r;
    else em = r;
  endtask

  // registers read zero after reset; unmapped place refuses
  task automatic check_reset();
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 10; i++) begin
      rd(12'(i * 4), q);
      cmp(q, 32'h00000000);
    end
    apb(1'b1, 12'h040, 32'hFFFFFFFF, q, e);
    cmp({31'h0, e}, 32'h00000001);
    apb(1'b0, 12'h040, 32'h00000000, q, e);
    cmp({31'h0, e}, 32'h00000001);
    cmp(q, 32'h00000000);
  endtask

  // load operands and flags, run one op, then judge work, flags and memory
  task automatic run_alu(input logic [4:0] op, input logic [9:0] a, input logic [7:0] w,
                         input logic [7:0] m, input logic [4:0] f);
    logic [7:0] ew, em, imm;
    logic [4:0] ef;
    logic [2:0] b;
    logic [31:0] q;
    imm = w ^ 8'hA5;
    b = m[2:0] ^ 3'h5;
    model(op, w, m, imm, b, f, ew, em, ef);
    wr(OFS_DMEM_PTR, {22'h0, a});
    wr(OFS_DMEM_DATA, {24'h0, m});
    wr(OFS_WORK, {24'h0, w});
    wr(OFS_FLAGS, {27'h0, f});
    wr(OFS_OPND_ADDR, {22'h0, a});
    wr(OFS_CMD, {8'h00, imm, 5'h00, b, 3'h0, op});
    @(negedge clk);
    cmp({31'h0, busy}, 32'h00000001);
    rd(OFS_WORK, q);
    cmp(q, {24'h0, ew});
    rd(OFS_FLAGS, q);
    cmp(q, {27'h0, ef});
    wr(OFS_DMEM_PTR, {22'h0, a});
    rd(OFS_DMEM_DATA, q);
    cmp(q, {24'h0, em});
    rd(OFS_WORK, q);
    cmp(q, {24'h0, ew});
  endtask

  // table fetch: pointer handling, latch, memory, flags kept
  task automatic run_table(input logic [4:0] op, input logic [7:0] tl, input logic [7:0] th,
                           input logic [9:0] a);
    logic [7:0] ntl;
    logic [13:0] pa;
    logic [15:0] wd;
    logic [31:0] q;
    ntl = (op == OP_TBL_PRE || op == OP_TBL_LAST_PRE) ? tl + 8'h01 : tl;
    pa = (op == OP_TBL_LAST || op == OP_TBL_LAST_PRE) ? {6'h3F, ntl} : {th[5:0], ntl};
    wd = pword(pa);
    wr(OFS_FLAGS, 32'h00000015);
    wr(OFS_TPTR_LOW, {24'h0, tl});
    wr(OFS_TPTR_HIGH, {24'h0, th});
    wr(OFS_OPND_ADDR, {22'h0, a});
    wr(OFS_CMD, {27'h0, op});
    @(negedge clk);
    cmp({30'h0, busy, prog_req}, 32'h00000002);
    @(negedge clk);
    cmp({17'h0, prog_req, prog_addr}, {17'h0, 1'b1, pa});
    rd(OFS_TPTR_LOW, q);
    cmp(q, {24'h0, ntl});
    rd(OFS_TLATCH, q);
    cmp(q, {24'h0, wd[15:8]});
    rd(OFS_FLAGS, q);
    cmp(q, 32'h00000015);
    wr(OFS_DMEM_PTR, {22'h0, a});
    rd(OFS_DMEM_DATA, q);
    cmp(q, {24'h0, wd[7:0]});
  endtask

  // hang guard, well beyond the expected run length
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    check_reset();
    for (int i = 0; i < 26; i++) begin
      run_alu(5'(i), 10'h3FF, 8'h3C, 8'hC3, 5'h00);
      run_alu(5'(i), 10'h155, 8'h7F, 8'h01, 5'h1F);
      run_alu(5'(i), 10'h000, 8'hAA, 8'h8F, 5'h0A);
    end
    run_table(OP_TBL_PAGED, 8'h34, 8'h2A, 10'h2C3);
    run_table(OP_TBL_LAST, 8'hFE, 8'h2A, 10'h3FE);
    run_table(OP_TBL_PRE, 8'hFF, 8'h15, 10'h001);
    run_table(OP_TBL_LAST_PRE, 8'h7F, 8'h15, 10'h200);
    report_and_stop();
  end
endmodule
